// ### include/cidf_cfg.svh
// Address map, field positions and sizes of the identifier tag and mask filter registers
`ifndef CIDF_CFG_SVH
`define CIDF_CFG_SVH

`define CIDF_TAG1_ADDR 8'hbc
`define CIDF_TAG2_ADDR 8'hbd
`define CIDF_TAG3_ADDR 8'hbe
`define CIDF_TAG4_ADDR 8'hbf
`define CIDF_MASK1_ADDR 8'hc4
`define CIDF_MASK2_ADDR 8'hc5

`define CIDF_NUM_OBJ 15
`define CIDF_OBJ_W 4
`define CIDF_ID_W 29
`define CIDF_STD_ID_W 11

`define CIDF_RTR_BIT 2
`define CIDF_RB1_BIT 1
`define CIDF_RB0_BIT 0

`define CIDF_ZERO_BYTE 8'h00
`define CIDF_STD_RSVD_LOW5 5'h00
`define CIDF_RSVD_HIGH5 5'h00
`define CIDF_ZERO_ID 29'h0000_0000

`endif

// ### include/cidf_pkg.sv
// Types shared by the tag and mask filter modules
`include "cidf_cfg.svh"
package cidf_pkg;
    typedef enum logic [0:0] {
        CIDF_FMT_STD = 1'b0,
        CIDF_FMT_EXT = 1'b1
    } cidf_fmt_e;

    typedef logic [`CIDF_ID_W-1:0] cidf_id_t;

    typedef struct packed {
        cidf_id_t id;
        logic rtr;
        logic rb1;
        logic rb0;
    } cidf_tag_s;
endpackage

// ### include/cidf_match_if.sv
// Carrier between one object's stored filter state and its acceptance comparator
`timescale 1ns/1ns
interface cidf_match_if;
    import cidf_pkg::*;
    cidf_tag_s tag;
    cidf_id_t mask;
    cidf_fmt_e fmt;
    logic rx_en;
    logic hit;
    modport regs (output tag, output mask, output fmt, output rx_en, input hit);
    modport cmp (input tag, input mask, input fmt, input rx_en, output hit);
endinterface

// ### src/cidf_match.sv
// Acceptance comparator for one message object
`timescale 1ns/1ns
`include "cidf_cfg.svh"
module cidf_match
    import cidf_pkg::*;
(
    cidf_match_if.cmp obj,
    input wire cidf_id_t rx_id_i,
    input wire logic rx_ext_i,
    input wire logic rx_rtr_i,
    input wire logic rx_rb1_i,
    input wire logic rx_rb0_i
);
    cidf_id_t bit_ok;
    logic id_ok;
    logic ctrl_ok;

    // Each bit passes when it matches the tag or its mask bit is clear
    assign bit_ok = ~(rx_id_i ^ obj.tag.id) | ~obj.mask;

    always_comb begin
        if (obj.fmt == CIDF_FMT_EXT) begin
            id_ok = &bit_ok;
            ctrl_ok = (rx_rtr_i == obj.tag.rtr) && (rx_rb1_i == obj.tag.rb1) && (rx_rb0_i == obj.tag.rb0);
        end else begin
            id_ok = &bit_ok[`CIDF_STD_ID_W-1:0];
            ctrl_ok = (rx_rtr_i == obj.tag.rtr) && (rx_rb0_i == obj.tag.rb0);
        end
    end

    // A frame of the other identifier format never hits
    assign obj.hit = obj.rx_en && (rx_ext_i == (obj.fmt == CIDF_FMT_EXT)) && id_ok && ctrl_ok;
endmodule

// ### src/cidf_tag_mask_regs.sv
// Per-object identifier tag and mask registers with reception acceptance filtering
`timescale 1ns/1ns
`include "cidf_cfg.svh"
module cidf_tag_mask_regs
    import cidf_pkg::*;
#(
    parameter int NUM_OBJ = `CIDF_NUM_OBJ,
    parameter int OBJ_W = `CIDF_OBJ_W
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    output logic [7:0] SFR_RDATA_O,
    input wire logic [OBJ_W-1:0] OBJ_SEL_I,
    input wire logic [NUM_OBJ-1:0] OBJ_EXT_FMT_I,
    input wire logic [NUM_OBJ-1:0] OBJ_RX_EN_I,
    input wire logic RX_FRAME_VALID_I,
    input wire logic [`CIDF_ID_W-1:0] RX_ID_I,
    input wire logic RX_EXT_I,
    input wire logic RX_RTR_I,
    input wire logic RX_RB1_I,
    input wire logic RX_RB0_I,
    output logic [NUM_OBJ-1:0] RX_HIT_O,
    output logic RX_HIT_VALID_O,
    input wire logic [OBJ_W-1:0] TX_OBJ_I,
    output logic [`CIDF_ID_W-1:0] TX_ID_O,
    output logic TX_EXT_O,
    output logic TX_RTR_O,
    output logic TX_RB1_O,
    output logic TX_RB0_O
);
    // Filter state is deliberately left without reset; software must load it first
    cidf_id_t id_tag_reg [NUM_OBJ];
    logic remote_request_tag_reg [NUM_OBJ];
    logic reserved_bit1_tag_reg [NUM_OBJ];
    logic reserved_bit0_tag_reg [NUM_OBJ];
    logic [`CIDF_ID_W-1:0] mask_field_reg [NUM_OBJ];

    logic sel_ok;
    logic sel_ext;
    logic [7:0] rdata_next;
    logic [NUM_OBJ-1:0] hit_vec;
    logic [NUM_OBJ-1:0] fmt_bits;
    logic tx_ok;

    assign sel_ok = (int'(OBJ_SEL_I) < NUM_OBJ);
    assign fmt_bits = OBJ_EXT_FMT_I;
    assign sel_ext = sel_ok && fmt_bits[OBJ_SEL_I];
    assign tx_ok = (int'(TX_OBJ_I) < NUM_OBJ);

    // Tag writes: layout follows the format of the selected object
    always_ff @(posedge CLK_I) begin
        if (SFR_WR_I && sel_ok) begin
            unique case (SFR_ADDR_I)
                `CIDF_TAG1_ADDR: begin
                    if (sel_ext) begin
                        id_tag_reg[OBJ_SEL_I][28:21] <= SFR_WDATA_I;
                    end else begin
                        id_tag_reg[OBJ_SEL_I][10:3] <= SFR_WDATA_I;
                    end
                end
                `CIDF_TAG2_ADDR: begin
                    if (sel_ext) begin
                        id_tag_reg[OBJ_SEL_I][20:13] <= SFR_WDATA_I;
                    end else begin
                        id_tag_reg[OBJ_SEL_I][2:0] <= SFR_WDATA_I[7:5];
                    end
                end
                `CIDF_TAG3_ADDR: begin
                    // Standard layout: register has no function, write dropped
                    if (sel_ext) begin
                        id_tag_reg[OBJ_SEL_I][12:5] <= SFR_WDATA_I;
                    end
                end
                `CIDF_TAG4_ADDR: begin
                    if (sel_ext) begin
                        id_tag_reg[OBJ_SEL_I][4:0] <= SFR_WDATA_I[7:3];
                        reserved_bit1_tag_reg[OBJ_SEL_I] <= SFR_WDATA_I[`CIDF_RB1_BIT];
                    end
                    remote_request_tag_reg[OBJ_SEL_I] <= SFR_WDATA_I[`CIDF_RTR_BIT];
                    reserved_bit0_tag_reg[OBJ_SEL_I] <= SFR_WDATA_I[`CIDF_RB0_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Mask writes share the same format steering as the tag
    always_ff @(posedge CLK_I) begin
        if (SFR_WR_I && sel_ok) begin
            unique case (SFR_ADDR_I)
                `CIDF_MASK1_ADDR: begin
                    if (sel_ext) begin
                        mask_field_reg[OBJ_SEL_I][28:21] <= SFR_WDATA_I;
                    end else begin
                        mask_field_reg[OBJ_SEL_I][10:3] <= SFR_WDATA_I;
                    end
                end
                `CIDF_MASK2_ADDR: begin
                    if (sel_ext) begin
                        mask_field_reg[OBJ_SEL_I][20:13] <= SFR_WDATA_I;
                    end else begin
                        mask_field_reg[OBJ_SEL_I][2:0] <= SFR_WDATA_I[7:5];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Readback; reserved positions return zero, which is one legal indeterminate value
    always_comb begin
        rdata_next = `CIDF_ZERO_BYTE;
        if (sel_ok) begin
            unique case (SFR_ADDR_I)
                `CIDF_TAG1_ADDR: begin
                    rdata_next = sel_ext ? id_tag_reg[OBJ_SEL_I][28:21] : id_tag_reg[OBJ_SEL_I][10:3];
                end
                `CIDF_TAG2_ADDR: begin
                    if (sel_ext) begin
                        rdata_next = id_tag_reg[OBJ_SEL_I][20:13];
                    end else begin
                        rdata_next = {id_tag_reg[OBJ_SEL_I][2:0], `CIDF_STD_RSVD_LOW5};
                    end
                end
                `CIDF_TAG3_ADDR: begin
                    rdata_next = sel_ext ? id_tag_reg[OBJ_SEL_I][12:5] : `CIDF_ZERO_BYTE;
                end
                `CIDF_TAG4_ADDR: begin
                    if (sel_ext) begin
                        rdata_next = {id_tag_reg[OBJ_SEL_I][4:0], remote_request_tag_reg[OBJ_SEL_I],
                                      reserved_bit1_tag_reg[OBJ_SEL_I], reserved_bit0_tag_reg[OBJ_SEL_I]};
                    end else begin
                        rdata_next = {`CIDF_RSVD_HIGH5, remote_request_tag_reg[OBJ_SEL_I], 1'b0,
                                      reserved_bit0_tag_reg[OBJ_SEL_I]};
                    end
                end
                `CIDF_MASK1_ADDR: begin
                    rdata_next = sel_ext ? mask_field_reg[OBJ_SEL_I][28:21] : mask_field_reg[OBJ_SEL_I][10:3];
                end
                `CIDF_MASK2_ADDR: begin
                    if (sel_ext) begin
                        rdata_next = mask_field_reg[OBJ_SEL_I][20:13];
                    end else begin
                        rdata_next = {mask_field_reg[OBJ_SEL_I][2:0], `CIDF_STD_RSVD_LOW5};
                    end
                end
                default: begin
                    rdata_next = `CIDF_ZERO_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            SFR_RDATA_O <= `CIDF_ZERO_BYTE;
        end else if (SFR_RD_I) begin
            SFR_RDATA_O <= rdata_next;
        end
    end

    // One comparator per object; all run in parallel on the same received frame
    genvar g;
    generate
        for (g = 0; g < NUM_OBJ; g++) begin : gen_obj
            cidf_match_if m_if ();
            cidf_id_t eff_mask;
            // Extended mask bits 12..0 have no register here and stay compare-enabled
            assign eff_mask = fmt_bits[g] ? {mask_field_reg[g][28:13], {13{1'b1}}} : mask_field_reg[g];
            assign m_if.tag = '{id: id_tag_reg[g], rtr: remote_request_tag_reg[g],
                                rb1: reserved_bit1_tag_reg[g], rb0: reserved_bit0_tag_reg[g]};
            assign m_if.mask = eff_mask;
            assign m_if.fmt = fmt_bits[g] ? CIDF_FMT_EXT : CIDF_FMT_STD;
            assign m_if.rx_en = OBJ_RX_EN_I[g];
            assign hit_vec[g] = m_if.hit;
            cidf_match u_match (
                .obj(m_if),
                .rx_id_i(RX_ID_I),
                .rx_ext_i(RX_EXT_I),
                .rx_rtr_i(RX_RTR_I),
                .rx_rb1_i(RX_RB1_I),
                .rx_rb0_i(RX_RB0_I)
            );
        end
    endgenerate

    // Hit vector is held until the next frame so the controller can pick its winner
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RX_HIT_O <= '0;
            RX_HIT_VALID_O <= 1'b0;
        end else begin
            RX_HIT_VALID_O <= RX_FRAME_VALID_I;
            if (RX_FRAME_VALID_I) begin
                RX_HIT_O <= hit_vec;
            end
        end
    end

    // Transmit side sees the raw tag; the mask never touches it
    always_ff @(posedge CLK_I) begin
        if (RST_I || !tx_ok) begin
            TX_ID_O <= `CIDF_ZERO_ID;
            TX_EXT_O <= 1'b0;
            TX_RTR_O <= 1'b0;
            TX_RB1_O <= 1'b0;
            TX_RB0_O <= 1'b0;
        end else begin
            TX_EXT_O <= fmt_bits[TX_OBJ_I];
            TX_ID_O <= fmt_bits[TX_OBJ_I] ? id_tag_reg[TX_OBJ_I]
                                          : {18'h00000, id_tag_reg[TX_OBJ_I][`CIDF_STD_ID_W-1:0]};
            TX_RTR_O <= remote_request_tag_reg[TX_OBJ_I];
            TX_RB1_O <= fmt_bits[TX_OBJ_I] & reserved_bit1_tag_reg[TX_OBJ_I];
            TX_RB0_O <= reserved_bit0_tag_reg[TX_OBJ_I];
        end
    end
endmodule

// ### verif/cidf_regs_asserts.sv
// Checker for register read layout, acceptance strobes and transmit tag presentation
`timescale 1ns/1ns
`include "cidf_cfg.svh"
module cidf_regs_chk
    import cidf_pkg::*;
#(parameter int NUM_OBJ = 15, parameter int OBJ_W = 4) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic [OBJ_W-1:0] OBJ_SEL_I,
    input wire logic [NUM_OBJ-1:0] OBJ_EXT_FMT_I,
    input wire logic [NUM_OBJ-1:0] OBJ_RX_EN_I,
    input wire logic RX_FRAME_VALID_I,
    input wire logic RX_EXT_I,
    input wire logic [NUM_OBJ-1:0] RX_HIT_O,
    input wire logic RX_HIT_VALID_O,
    input wire logic [OBJ_W-1:0] TX_OBJ_I,
    input wire logic [`CIDF_ID_W-1:0] TX_ID_O,
    input wire logic TX_RB1_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_std_rd(a);
        SFR_RD_I && SFR_ADDR_I == a && OBJ_SEL_I < NUM_OBJ && !OBJ_EXT_FMT_I[OBJ_SEL_I];
    endsequence
    property p_hit_on; RX_FRAME_VALID_I |=> RX_HIT_VALID_O; endproperty
    a_hit_on: assert property (p_hit_on) else $error("hit strobe missing");
    property p_hit_off; !RX_FRAME_VALID_I |=> !RX_HIT_VALID_O; endproperty
    a_hit_off: assert property (p_hit_off) else $error("hit strobe without frame");
    property p_hit_hold; !RX_FRAME_VALID_I |=> $stable(RX_HIT_O); endproperty
    a_hit_hold: assert property (p_hit_hold) else $error("hit vector moved between frames");
    property p_hit_en; RX_FRAME_VALID_I |=> (RX_HIT_O & ~$past(OBJ_RX_EN_I)) == '0; endproperty
    a_hit_en: assert property (p_hit_en) else $error("disabled object hit");
    property p_hit_fmt;
        RX_FRAME_VALID_I |=> (RX_HIT_O & ($past(RX_EXT_I) ? ~$past(OBJ_EXT_FMT_I) : $past(OBJ_EXT_FMT_I))) == '0;
    endproperty
    a_hit_fmt: assert property (p_hit_fmt) else $error("hit on wrong format");
    property p_std_t2; s_std_rd(8'hbd) |=> SFR_RDATA_O[4:0] == 5'h00; endproperty
    a_std_t2: assert property (p_std_t2) else $error("tag two low bits set");
    property p_std_t3; s_std_rd(8'hbe) |=> SFR_RDATA_O == 8'h00; endproperty
    a_std_t3: assert property (p_std_t3) else $error("tag three not empty");
    property p_std_t4; s_std_rd(8'hbf) |=> SFR_RDATA_O[7:3] == 5'h00 && !SFR_RDATA_O[1]; endproperty
    a_std_t4: assert property (p_std_t4) else $error("tag four reserved bits set");
    property p_std_m2; s_std_rd(8'hc5) |=> SFR_RDATA_O[4:0] == 5'h00; endproperty
    a_std_m2: assert property (p_std_m2) else $error("mask two low bits set");
    property p_tx_std;
        TX_OBJ_I < NUM_OBJ && !OBJ_EXT_FMT_I[TX_OBJ_I] |=> TX_ID_O[28:11] == 18'h0 && !TX_RB1_O;
    endproperty
    a_tx_std: assert property (p_tx_std) else $error("standard transmit shows extended bits");
endmodule

bind cidf_tag_mask_regs cidf_regs_chk #(.NUM_OBJ(NUM_OBJ), .OBJ_W(OBJ_W)) i_chk (.CLK_I(CLK_I), .RST_I(RST_I),
    .SFR_ADDR_I(SFR_ADDR_I), .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O), .OBJ_SEL_I(OBJ_SEL_I),
    .OBJ_EXT_FMT_I(OBJ_EXT_FMT_I), .OBJ_RX_EN_I(OBJ_RX_EN_I), .RX_FRAME_VALID_I(RX_FRAME_VALID_I),
    .RX_EXT_I(RX_EXT_I), .RX_HIT_O(RX_HIT_O), .RX_HIT_VALID_O(RX_HIT_VALID_O), .TX_OBJ_I(TX_OBJ_I),
    .TX_ID_O(TX_ID_O), .TX_RB1_O(TX_RB1_O));

// ### verif/cidf_frame_src.sv
// Received frame source standing in for the bus side of the filter
`timescale 1ns/1ns
module cidf_frame_src (
    input wire logic clk_i,
    output logic valid_o,
    output logic [28:0] id_o,
    output logic ext_o,
    output logic rtr_o,
    output logic rb1_o,
    output logic rb0_o
);
    initial begin
        valid_o = 1'b0;
        {id_o, ext_o, rtr_o, rb1_o, rb0_o} = '0;
    end
    task automatic send(input logic [32:0] f);
        @(posedge clk_i);
        #2;
        valid_o = 1'b1;
        {id_o, ext_o, rtr_o, rb1_o, rb0_o} = f;
        @(posedge clk_i);
        #2;
        valid_o = 1'b0;
        // Fields mean nothing without the strobe, so show junk rather than the old frame
        {id_o, ext_o, rtr_o, rb1_o, rb0_o} = ~f;
    endtask
endmodule

// ### verif/cidf_tag_mask_regs_test.sv
// Self-checking bench for the tag and mask filter registers
`timescale 1ns/1ns
module cidf_tag_mask_regs_test;
    import cidf_pkg::*;
    logic clk, rst, wr, rd, fv, ext, rtr, rb1, rb0, hv, txe, txr, tx1, tx0;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] sel, txo;
    logic [14:0] fmt, rxen, hit;
    logic [28:0] id, txid;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    cidf_tag_mask_regs i_dut (.CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .SFR_WR_I(wr),
        .SFR_RD_I(rd), .SFR_RDATA_O(rdata), .OBJ_SEL_I(sel), .OBJ_EXT_FMT_I(fmt), .OBJ_RX_EN_I(rxen),
        .RX_FRAME_VALID_I(fv), .RX_ID_I(id), .RX_EXT_I(ext), .RX_RTR_I(rtr), .RX_RB1_I(rb1), .RX_RB0_I(rb0),
        .RX_HIT_O(hit), .RX_HIT_VALID_O(hv), .TX_OBJ_I(txo), .TX_ID_O(txid), .TX_EXT_O(txe), .TX_RTR_O(txr),
        .TX_RB1_O(tx1), .TX_RB0_O(tx0));
    cidf_frame_src i_src (.clk_i(clk), .valid_o(fv), .id_o(id), .ext_o(ext), .rtr_o(rtr), .rb1_o(rb1),
        .rb0_o(rb0));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        {addr, wdata, wr} = {a, d, 1'b1};
        @(posedge clk);
        #2;
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        {addr, rd} = {a, 1'b1};
        @(posedge clk);
        #2;
        rd = 1'b0;
        chk(rdata, e);
    endtask
    task automatic tx_chk(input logic [3:0] o, input logic [32:0] e);
        @(posedge clk);
        #2;
        txo = o;
        @(posedge clk);
        #2;
        chk({txid, txe, txr, tx1, tx0}, e);
    endtask
    task automatic frame(input logic [32:0] f, input logic [14:0] e);
        i_src.send(f);
        chk({hv, hit}, {1'b1, e});
    endtask
    task automatic t_std;
        sel = 4'h0;
        wr_reg(8'hbc, 8'ha5);
        wr_reg(8'hbd, 8'he0);
        wr_reg(8'hbf, 8'h05);
        wr_reg(8'hc4, 8'hff);
        wr_reg(8'hc5, 8'he0);
        rd_reg(8'hbc, 8'ha5);
        rd_reg(8'hbd, 8'he0);
        rd_reg(8'hbe, 8'h00);
        rd_reg(8'hbf, 8'h05);
        rd_reg(8'hc4, 8'hff);
        rd_reg(8'hc5, 8'he0);
        tx_chk(4'h0, {18'h0, 11'h52f, 4'b0101});
        $display("test std layout done");
    endtask
    task automatic t_ext;
        sel = 4'h1;
        wr_reg(8'hbc, 8'h9a);
        wr_reg(8'hbd, 8'hbc);
        wr_reg(8'hbe, 8'hde);
        wr_reg(8'hbf, 8'hf2);
        wr_reg(8'hc4, 8'hff);
        wr_reg(8'hc5, 8'hff);
        rd_reg(8'hbc, 8'h9a);
        rd_reg(8'hbd, 8'hbc);
        rd_reg(8'hbe, 8'hde);
        rd_reg(8'hbf, 8'hf2);
        rd_reg(8'hc4, 8'hff);
        rd_reg(8'hc5, 8'hff);
        tx_chk(4'h1, {8'h9a, 8'hbc, 8'hde, 5'h1e, 4'b1010});
        $display("test ext layout done");
    endtask
    task automatic t_filter;
        rxen = 15'h0003;
        frame({18'h0, 11'h52f, 4'b0101}, 15'h0001);
        frame({18'h0, 11'h52e, 4'b0101}, 15'h0000);
        frame({18'h0, 11'h52f, 4'b0001}, 15'h0000);
        frame({18'h0, 11'h52f, 4'b1101}, 15'h0000);
        frame({8'h9a, 8'hbc, 8'hde, 5'h1e, 4'b1010}, 15'h0002);
        frame({8'h9a, 8'hbc, 8'hde, 5'h1e, 4'b1000}, 15'h0000);
        sel = 4'h0;
        wr_reg(8'hc5, 8'h00);
        frame({18'h0, 11'h52e, 4'b0101}, 15'h0001);
        rxen = 15'h0002;
        frame({18'h0, 11'h52f, 4'b0101}, 15'h0000);
        $display("test filter done");
    endtask
    task automatic t_reset;
        @(posedge clk);
        #2;
        rst = 1'b1;
        @(posedge clk);
        #2;
        rst = 1'b0;
        chk({rdata, hv, hit}, 24'h000000);
        chk({txid, txe, txr, tx1, tx0}, 33'h0);
        sel = 4'h1;
        rd_reg(8'hbc, 8'h9a);
        sel = 4'hf;
        rd_reg(8'hbc, 8'h00);
        tx_chk(4'hf, 33'h0);
        $display("test reset done");
    endtask
    initial begin
        {rst, wr, rd} = 3'b100;
        {addr, wdata, sel, txo} = '0;
        fmt = 15'h0002;
        rxen = 15'h0000;
        repeat (3) @(posedge clk);
        #2;
        rst = 1'b0;
        t_std();
        t_ext();
        t_filter();
        t_reset();
        give_verdict();
    end
endmodule
